// file: sesc_pkg.sv
// Package of constants for the serial EEPROM select and clocking front end
`default_nettype none
package sesc_pkg;
	// Word and address widths per organisation
	localparam int unsigned ADDR_W16 = 10;
	localparam int unsigned ADDR_W8 = 11;
	localparam int unsigned DATA_W16 = 16;
	localparam int unsigned DATA_W8 = 8;
	localparam int unsigned OPC_W = 2;
	localparam int unsigned CNT_W = 5;
	// Timing in ns, serial clock rate in kHz, and system clock
	localparam int unsigned REF_CLK_PERIOD_NS = 20;
	localparam int unsigned MIN_DESELECT_TIME_NS = 1000;
	localparam int unsigned MAX_SERIAL_CLOCK_RATE_KHZ = 250;
	// Least deselect interval rounded up to whole system cycles
	localparam int unsigned DESEL_CYCLES = (MIN_DESELECT_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int unsigned DESEL_CNT_W = 8;
	// Opcodes
	localparam logic [1:0] OPC_READ = 2'h2;
	localparam logic [1:0] OPC_WRITE = 2'h1;
	localparam logic [1:0] OPC_ERASE = 2'h3;
	localparam logic [1:0] OPC_SPECIAL = 2'h0;
	// Link phases
	typedef enum logic [2:0] {
		SESC_IDLE = 3'b000,
		SESC_OPC = 3'b001,
		SESC_ADDR = 3'b010,
		SESC_DATA = 3'b011,
		SESC_READ = 3'b100,
		SESC_DONE = 3'b101
	} sesc_state_t;
endpackage
`default_nettype wire

// file: sesc_cmd_if.sv
// Interface carrying a decoded instruction from the link domain to the core
`default_nettype none
interface sesc_cmd_if;
	import sesc_pkg::*;
	logic toggle;
	logic [1:0] opcode;
	logic [ADDR_W8-1:0] addr;
	logic [DATA_W16-1:0] data;
	modport src (output toggle, output opcode, output addr, output data);
	modport dst (input toggle, input opcode, input addr, input data);
endinterface
`default_nettype wire

// file: sesc_link.sv
// Link-side shift logic clocked by the serial clock
`default_nettype none
module sesc_link
	import sesc_pkg::*;
(
	// Link clock and select
	input wire logic serial_clock,
	input wire logic sel,
	input wire logic serial_data_in,
	input wire logic word_width_select,
	// Clear of the event toggle, from the system domain
	input wire logic rst,
	// Read data from the core
	input wire logic [DATA_W16-1:0] rd_data,
	// Output bit and enable
	output logic dout,
	output logic dout_oe,
	// Decoded instruction
	sesc_cmd_if.src cmd
);
	sesc_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [1:0] opc_q, opc_d;
	logic [ADDR_W8-1:0] addr_q, addr_d;
	logic [DATA_W16-1:0] sh_q, sh_d;
	logic dout_q, dout_d, oe_q, oe_d, tog_q, tog_d;
	logic [1:0] hold_opc_q, hold_opc_d;
	logic [ADDR_W8-1:0] hold_addr_q, hold_addr_d;
	logic [DATA_W16-1:0] hold_data_q, hold_data_d;
	logic [CNT_W-1:0] alen, dlen;

	// Field lengths from the word width
	assign alen = word_width_select ? CNT_W'(ADDR_W16) : CNT_W'(ADDR_W8);
	assign dlen = word_width_select ? CNT_W'(DATA_W16) : CNT_W'(DATA_W8);

	// Next-state decoding of the serial frame
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		opc_d = opc_q;
		addr_d = addr_q;
		sh_d = sh_q;
		dout_d = dout_q;
		oe_d = oe_q;
		tog_d = tog_q;
		hold_opc_d = hold_opc_q;
		hold_addr_d = hold_addr_q;
		hold_data_d = hold_data_q;
		unique case (state_q)
			SESC_IDLE: begin
				if (serial_data_in) begin
					state_d = SESC_OPC;
					cnt_d = '0;
				end
			end
			SESC_OPC: begin
				opc_d = {opc_q[0], serial_data_in};
				if (cnt_q == CNT_W'(OPC_W - 1)) begin
					state_d = SESC_ADDR;
					cnt_d = '0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			SESC_ADDR: begin
				addr_d = {addr_q[ADDR_W8-2:0], serial_data_in};
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == alen - 1'b1) begin
					cnt_d = '0;
					if (opc_q == OPC_READ) begin
						state_d = SESC_READ;
						dout_d = 1'b0;
						oe_d = 1'b1;
						sh_d = word_width_select ? rd_data : {rd_data[DATA_W8-1:0], {DATA_W8{1'b0}}};
					end else if (opc_q == OPC_WRITE ||
						(opc_q == OPC_SPECIAL && alen >= CNT_W'(2) &&
						addr_d[alen-1 -: 2] == 2'b01)) begin
						state_d = SESC_DATA;
					end else begin
						state_d = SESC_DONE;
						tog_d = ~tog_q;
					end
				end
			end
			SESC_DATA: begin
				sh_d = {sh_q[DATA_W16-2:0], serial_data_in};
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == dlen - 1'b1) begin
					state_d = SESC_DONE;
					tog_d = ~tog_q;
				end
			end
			SESC_READ: begin
				dout_d = sh_q[DATA_W16-1];
				sh_d = {sh_q[DATA_W16-2:0], 1'b0};
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == dlen) begin
					state_d = SESC_DONE;
					dout_d = 1'b0;
				end
			end
			SESC_DONE: begin
				state_d = SESC_DONE;
			end
			default: state_d = SESC_IDLE;
		endcase
		// Freeze the finished command so that a fast deselect cannot wipe it
		if (tog_d != tog_q) begin
			hold_opc_d = opc_d;
			hold_addr_d = addr_d;
			hold_data_d = sh_d;
		end
	end

	// select low holds idle, rise starts fresh
	always_ff @(posedge serial_clock or negedge sel) begin
		if (!sel) begin
			state_q <= SESC_IDLE;
			cnt_q <= '0;
			opc_q <= '0;
			addr_q <= '0;
			sh_q <= '0;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			opc_q <= opc_d;
			addr_q <= addr_d;
			sh_q <= sh_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
		end
	end

	// Event toggle survives deselect; only the system reset clears it, with the serial clock idle
	always_ff @(posedge serial_clock or posedge rst) begin
		if (rst) begin
			tog_q <= 1'b0;
		end else begin
			tog_q <= tog_d;
		end
	end

	// Held command, written only at the edge that ends a frame
	always_ff @(posedge serial_clock) begin
		hold_opc_q <= hold_opc_d;
		hold_addr_q <= hold_addr_d;
		hold_data_q <= hold_data_d;
	end

	assign dout = dout_q;
	assign dout_oe = oe_q; // Select low clears oe_q at once
	assign cmd.toggle = tog_q;
	assign cmd.opcode = hold_opc_q;
	assign cmd.addr = hold_addr_q;
	assign cmd.data = hold_data_q;
endmodule
`default_nettype wire

// file: sesc_top.sv
// Top of the serial EEPROM select and clocking front end
`default_nettype none
module sesc_top
	import sesc_pkg::*;
(
	// System clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Serial link
	input wire logic SERIAL_CLOCK,
	input wire logic SELECT,
	input wire logic SERIAL_DATA_IN,
	input wire logic WORD_WIDTH_SELECT,
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OUT_OE,
	// Core side
	input wire logic [DATA_W16-1:0] READ_DATA,
	output logic CMD_VALID,
	output logic [1:0] CMD_OPCODE,
	output logic [ADDR_W8-1:0] CMD_ADDR,
	output logic [DATA_W16-1:0] CMD_DATA,
	output logic DESELECT_MET
);
	sesc_cmd_if cmd_bus();
	logic link_dout, link_oe;
	logic [2:0] tog_sync_q, tog_sync_d;
	logic [1:0] sel_sync_q, sel_sync_d;
	logic valid_q, valid_d;
	logic [1:0] opc_q, opc_d;
	logic [ADDR_W8-1:0] addr_q, addr_d;
	logic [DATA_W16-1:0] data_q, data_d;
	logic [DESEL_CNT_W-1:0] dcnt_q, dcnt_d;
	logic met_q, met_d;
	logic link_rst_q, link_rst_d;

	// link logic active only while selected
	sesc_link u_link (
		.serial_clock(SERIAL_CLOCK),
		.sel(SELECT),
		.serial_data_in(SERIAL_DATA_IN),
		.word_width_select(WORD_WIDTH_SELECT),
		.rst(link_rst_q),
		.rd_data(READ_DATA),
		.dout(link_dout),
		.dout_oe(link_oe),
		.cmd(cmd_bus.src)
	);

	// Pins driven from the link domain flops
	assign SERIAL_DATA_OUT = link_dout;
	assign SERIAL_DATA_OUT_OE = link_oe;

	// Crossing of the event toggle and the select level
	always_comb begin
		tog_sync_d = {tog_sync_q[1:0], cmd_bus.toggle};
		sel_sync_d = {sel_sync_q[0], SELECT};
		valid_d = tog_sync_q[2] ^ tog_sync_q[1];
		// Registered copy of reset that clears the link toggle
		link_rst_d = 1'b0;
		opc_d = opc_q;
		addr_d = addr_q;
		data_d = data_q;
		// Fields are stable once the toggle has crossed
		if (tog_sync_q[2] ^ tog_sync_q[1]) begin
			opc_d = cmd_bus.opcode;
			addr_d = cmd_bus.addr;
			data_d = cmd_bus.data;
		end
		dcnt_d = dcnt_q;
		met_d = met_q;
		if (sel_sync_q[1]) begin
			dcnt_d = '0;
			met_d = 1'b0;
		end else if (dcnt_q < DESEL_CNT_W'(DESEL_CYCLES)) begin
			dcnt_d = dcnt_q + 1'b1;
		end else begin
			met_d = 1'b1;
		end
	end

	// Registers of the system domain
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tog_sync_q <= '0;
			sel_sync_q <= '0;
			valid_q <= 1'b0;
			opc_q <= '0;
			addr_q <= '0;
			data_q <= '0;
			dcnt_q <= '0;
			met_q <= 1'b0;
			link_rst_q <= 1'b1;
		end else begin
			tog_sync_q <= tog_sync_d;
			sel_sync_q <= sel_sync_d;
			valid_q <= valid_d;
			opc_q <= opc_d;
			addr_q <= addr_d;
			data_q <= data_d;
			dcnt_q <= dcnt_d;
			met_q <= met_d;
			link_rst_q <= link_rst_d;
		end
	end

	assign CMD_VALID = valid_q;
	assign CMD_OPCODE = opc_q;
	assign CMD_ADDR = addr_q;
	assign CMD_DATA = data_q;
	assign DESELECT_MET = met_q;
endmodule
`default_nettype wire

// file: sesc_top_properties.sv
// Checker of the select and clocking front end
`default_nettype none
module sesc_chk
	import sesc_pkg::*;
(
	// Clock, reset and link
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic SERIAL_CLOCK,
	input wire logic SELECT,
	input wire logic SERIAL_DATA_OUT,
	input wire logic SERIAL_DATA_OUT_OE,
	// Core side
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_OPCODE,
	input wire logic [ADDR_W8-1:0] CMD_ADDR,
	input wire logic [DATA_W16-1:0] CMD_DATA,
	input wire logic DESELECT_MET
);
	logic [7:0] low_q, low_d;
	// Cycles with select low, saturating
	always_comb begin
		low_d = (RST || SELECT) ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
	end
	always_ff @(posedge REF_CLK) begin
		low_q <= low_d;
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence s_sel_rise;
		$rose(SELECT);
	endsequence
	sequence s_quiet;
		!SERIAL_DATA_OUT_OE [*8];
	endsequence
	a_oe_gated: assert property (!SELECT |-> !SERIAL_DATA_OUT_OE)
		else $error("output enabled while deselected");
	a_idle_after_select: assert property (s_sel_rise |-> s_quiet)
		else $error("output enabled soon after select rise");
	a_dummy_zero: assert property ($rose(SERIAL_DATA_OUT_OE) |-> !SERIAL_DATA_OUT)
		else $error("first output bit not zero");
	a_dout_on_rise: assert property ($changed(SERIAL_DATA_OUT) && SELECT && $past(SELECT) |-> $rose(SERIAL_CLOCK))
		else $error("output moved without a clock rise");
	a_valid_single: assert property (CMD_VALID |=> !CMD_VALID [*8])
		else $error("command pulse too long");
	a_fields_hold: assert property (!CMD_VALID |-> $stable({CMD_OPCODE, CMD_ADDR, CMD_DATA}))
		else $error("command fields moved");
	a_desel_not_early: assert property ($rose(DESELECT_MET) |-> low_q >= 8'h31)
		else $error("deselect flag early");
	a_desel_due: assert property (low_q == 8'h3C |-> DESELECT_MET)
		else $error("deselect flag late");
endmodule
bind sesc_top sesc_chk i_sesc_chk (.REF_CLK(REF_CLK), .RST(RST), .SERIAL_CLOCK(SERIAL_CLOCK), .SELECT(SELECT),
	.SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .CMD_VALID(CMD_VALID),
	.CMD_OPCODE(CMD_OPCODE), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .DESELECT_MET(DESELECT_MET));
`default_nettype wire

// file: sesc_master_model.sv
// Behavioural master that frames instructions on the link
`default_nettype none
module sesc_master_model (
	// Link to the device
	output logic sk,
	output logic sel,
	output logic din,
	input wire logic dout
);
	timeunit 1ns;
	timeprecision 1ps;
	parameter int HALF = 24;
	logic [16:0] rx;
	initial begin
		sk = 1'b0;
		sel = 1'b0;
		din = 1'b0;
	end
	task automatic frame(input logic s, input logic [31:0] bits, input int n);
		#7;
		sel <= s;
		for (int i = n - 1; i >= 0; i--) begin
			din <= bits[i];
			#HALF;
			rx = {rx[15:0], dout};
			sk <= 1'b1;
			#HALF;
			sk <= 1'b0;
		end
		#HALF;
		rx = {rx[15:0], dout};
		sel <= 1'b0;
		din <= ~din;
		// deselect and wait out minimum deselect time
		#1200;
	endtask
endmodule
`default_nettype wire

// file: serial_eeprom_select_and_clocking_tb.sv
// Self-checking bench for the select and clocking front end
`default_nettype none
module serial_eeprom_select_and_clocking_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sesc_pkg::*;
	typedef struct {logic ww; logic [31:0] b; int n; logic [1:0] op; logic [10:0] a; logic [15:0] d;} sesc_row_t;
	logic ref_clk, rst, sk, sel, din, ww, dout, oe, valid, met;
	logic [15:0] rd, cdat;
	logic [1:0] cop;
	logic [10:0] cadr;
	int mismatches, checks_done, nvalid, cyc;
	sesc_row_t rows[7];
	sesc_top i_sesc_top (.REF_CLK(ref_clk), .RST(rst), .SERIAL_CLOCK(sk), .SELECT(sel), .SERIAL_DATA_IN(din),
		.WORD_WIDTH_SELECT(ww), .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OUT_OE(oe), .READ_DATA(rd),
		.CMD_VALID(valid), .CMD_OPCODE(cop), .CMD_ADDR(cadr), .CMD_DATA(cdat), .DESELECT_MET(met));
	// Released output line shows the inverse of the last bit
	sesc_master_model i_sesc_master_model (.sk(sk), .sel(sel), .din(din), .dout(oe ? dout : ~dout));
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Counts command pulses and cuts a hang short
	always @(posedge ref_clk) begin
		cyc++;
		nvalid += (valid === 1'b1);
		if (cyc == 6000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		rst <= 1'b1;
		ww <= 1'b1;
		rd <= 16'hC3A5;
		rows[0] = '{1'b1, {3'h5, 10'h3FF, 16'hA5C3}, 29, 2'h1, 11'h3FF, 16'hA5C3};
		rows[1] = '{1'b1, {3'h7, 10'h000}, 13, 2'h3, 11'h000, 16'h0000};
		rows[2] = '{1'b1, {3'h4, 10'h100, 16'h1234}, 29, 2'h0, 11'h100, 16'h1234};
		rows[3] = '{1'b1, {3'h4, 10'h055}, 16, 2'h0, 11'h055, 16'h0000};
		rows[4] = '{1'b0, {3'h5, 11'h7FF, 8'h5A}, 22, 2'h1, 11'h7FF, 16'h005A};
		rows[5] = '{1'b1, {3'h6, 10'h155, 16'h0000}, 29, 2'h2, 11'h155, 16'hC3A5};
		rows[6] = '{1'b0, {3'h6, 11'h4AB, 8'h00}, 22, 2'h2, 11'h4AB, 16'h00A5};
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (rows[i]) begin
			ww <= rows[i].ww;
			@(posedge ref_clk);
			nvalid = 0;
			i_sesc_master_model.frame(1'b1, rows[i].b, rows[i].n);
			if (rows[i].op == OPC_READ) begin
				chk(i_sesc_master_model.rx & (rows[i].ww ? 17'h1_FFFF : 17'h0_01FF), {1'h0, rows[i].d});
			end else begin
				chk(17'(nvalid), 17'h0_0001);
				chk({4'h0, cop, cadr & (ww ? 11'h3FF : 11'h7FF)}, {4'h0, rows[i].op, rows[i].a});
				if (rows[i].d != 16'h0000) chk({1'h0, cdat & (ww ? 16'hFFFF : 16'h00FF)}, {1'h0, rows[i].d});
			end
			$display("row %0d done", i);
		end
		nvalid = 0;
		i_sesc_master_model.frame(1'b0, {3'h5, 11'h7FF, 8'hFF}, 22);
		i_sesc_master_model.frame(1'b1, 32'h0000_0005, 3);
		chk(17'(nvalid), 17'h0_0000);
		i_sesc_master_model.frame(1'b1, {3'h5, 11'h123, 8'hC6}, 22);
		chk({4'h0, cop, cadr}, {4'h0, 2'h1, 11'h123});
		chk({9'h000, cdat[7:0]}, {9'h000, 8'hC6});
		chk({16'h0000, met}, 17'h0_0001);
		$display("abort test done");
		rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk({3'h0, cop, cadr, met}, 17'h0_0000);
		chk({1'h0, cdat}, 17'h0_0000);
		$display("reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
